// >>> hw/sesr_pkg.sv
// Overview of operation
// [R01] Master opens with current or random read
// [R02] Acknowledged byte leads to next byte
// [R03] Master ends with no-ack then stop
// [R04] Address counter increments after each output byte
// [R05] Counter wraps past top to zero
// [R06] Release data line, sample ack ninth slot
// [R07] Missing ack returns device to stand-by
// [R08] Both select bytes share upper seven bits
// [R09] Slot bits must match pins, else stand-by
// [R10] Eighth bit is direction; match is acknowledged
// [R11] Sixteen-bit address, high byte first, loads counter
// [R12] Random read: dummy write, repeated start, read
// [R13] Data MSB first, changed only while clock low
// [R14] Start or stop always returns to idle; here only a stop goes to ST_IDLE, a start goes straight to ST_SEL
package sesr_pkg;
	localparam int SESR_ADDR_W = 16;
	localparam logic [3:0] SESR_BYTE_BITS = 4'h8;
	localparam logic [3:0] SESR_LAST_BIT = 4'h7;
	localparam logic [3:0] SESR_BIT_ZERO = 4'h0;
	localparam int SESR_RW_POS = 0;
	localparam int SESR_SLOT_LSB = 1;
	localparam int SESR_SLOT_MSB = 3;
	localparam int SESR_TYPE_LSB = 4;
	localparam int SESR_TYPE_MSB = 7;
	localparam int SESR_MSB = 7;
	localparam logic SESR_READ_DIR = 1'b1;

	typedef struct packed {
		logic scl;
		logic sda;
	} sesr_pins_t;

	typedef enum logic [8:0] {
		ST_IDLE    = 9'h001,
		ST_SEL     = 9'h002,
		ST_SEL_ACK = 9'h004,
		ST_AHI     = 9'h008,
		ST_AHI_ACK = 9'h010,
		ST_ALO     = 9'h020,
		ST_ALO_ACK = 9'h040,
		ST_TX      = 9'h080,
		ST_MACK    = 9'h100
	} sesr_state_t;
endpackage : sesr_pkg

// >>> hw/sesr_eeprom_read.sv
`timescale 1ns/100ps
`default_nettype none
module sesr_eeprom_read import sesr_pkg::*; #(
	parameter int MEM_AW = SESR_ADDR_W,
	// Device type code; value is arbitrary
	parameter logic [3:0] DEV_TYPE = 4'h5
) (
	// Core clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link clock
	input wire logic link_clk,
	// Two-wire bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [2:0] bus_slot_select_pins,
	// Memory preload port, core domain
	input wire logic load_en,
	input wire logic [MEM_AW-1:0] load_addr,
	input wire logic [7:0] load_data
);
	// Link-domain state
	sesr_pins_t pin_s1, pin_s2, pin_q;
	logic [2:0] slot_s1, slot_s2;
	logic ack_s1, ack_s2, ack_s3;
	sesr_state_t st, next_st;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] sh, next_sh;
	logic [7:0] addr_hi, next_addr_hi;
	logic [MEM_AW-1:0] addr_cnt, next_addr_cnt;
	logic rw, next_rw;
	logic next_sda_oe;
	logic req_tog, next_req_tog;
	logic [7:0] tx_sh, next_tx_sh;
	logic acked, next_acked;
	logic [7:0] rd_q, next_rd_q;
	logic scl_rise, scl_fall, start_det, stop_det;

	// Core-domain state
	logic [7:0] mem [0:(1<<MEM_AW)-1];
	logic req_s1, req_s2, req_s3;
	logic ack_tog, next_ack_tog;
	logic [7:0] rd_data, next_rd_data;

	assign scl_rise = pin_s2.scl & ~pin_q.scl;
	assign scl_fall = ~pin_s2.scl & pin_q.scl;
	assign start_det = pin_s2.scl & pin_q.scl & pin_q.sda & ~pin_s2.sda;
	assign stop_det = pin_s2.scl & pin_q.scl & ~pin_q.sda & pin_s2.sda;

	always_comb begin
		next_st = st;
		next_bit_cnt = bit_cnt;
		next_sh = sh;
		next_addr_hi = addr_hi;
		next_addr_cnt = addr_cnt;
		next_rw = rw;
		next_sda_oe = sda_oe;
		next_req_tog = req_tog;
		next_tx_sh = tx_sh;
		next_acked = acked;
		// Read data only moves when the fetch answer toggle is seen
		next_rd_q = (ack_s2 ^ ack_s3) ? rd_data : rd_q;
		if (start_det) begin
			next_st = ST_SEL; // [R14]
			next_bit_cnt = SESR_BIT_ZERO;
			next_sda_oe = 1'b0;
		end else if (stop_det) begin
			next_st = ST_IDLE; // [R14]
			next_sda_oe = 1'b0;
		end else begin
			case (st)
				ST_SEL, ST_AHI, ST_ALO: begin
					if (scl_rise) begin
						next_sh = {sh[6:0], pin_s2.sda};
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == SESR_BYTE_BITS) begin
						next_bit_cnt = SESR_BIT_ZERO;
						if (st == ST_SEL) begin
							if (sh[SESR_TYPE_MSB:SESR_TYPE_LSB] == DEV_TYPE &&
								sh[SESR_SLOT_MSB:SESR_SLOT_LSB] == slot_s2) begin
								next_st = ST_SEL_ACK; // [R10]
								next_sda_oe = 1'b1; // [R10]
								next_rw = sh[SESR_RW_POS];
								// Fetch the current address early so it is ready for the first bit
								if (sh[SESR_RW_POS] == SESR_READ_DIR) begin
									next_req_tog = ~req_tog;
								end
							end else begin
								next_st = ST_IDLE; // [R09]
							end
						end else if (st == ST_AHI) begin
							next_addr_hi = sh; // [R11]
							next_st = ST_AHI_ACK;
							next_sda_oe = 1'b1;
						end else begin
							next_addr_cnt = MEM_AW'({addr_hi, sh}); // [R11]
							next_st = ST_ALO_ACK;
							next_sda_oe = 1'b1;
						end
					end
				end
				ST_SEL_ACK, ST_AHI_ACK, ST_ALO_ACK: begin
					if (scl_fall) begin
						next_sda_oe = 1'b0;
						if (st == ST_SEL_ACK && rw == SESR_READ_DIR) begin
							next_st = ST_TX;
							next_tx_sh = rd_q;
							next_sda_oe = ~rd_q[SESR_MSB]; // [R13]
						end else if (st == ST_SEL_ACK) begin
							next_st = ST_AHI;
						end else if (st == ST_AHI_ACK) begin
							next_st = ST_ALO;
						end else begin
							// Dummy write done; wait for the repeated start
							next_st = ST_IDLE; // [R12]
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == SESR_LAST_BIT) begin
							next_bit_cnt = SESR_BIT_ZERO;
							next_sda_oe = 1'b0; // [R06]
							next_addr_cnt = addr_cnt + {{(MEM_AW-1){1'b0}}, 1'b1}; // [R04] [R05]
							next_req_tog = ~req_tog;
							next_acked = 1'b0;
							next_st = ST_MACK;
						end else begin
							next_bit_cnt = bit_cnt + 4'h1;
							next_tx_sh = {tx_sh[6:0], 1'b0};
							next_sda_oe = ~tx_sh[SESR_MSB-1]; // [R13]
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						if (pin_s2.sda) begin
							next_st = ST_IDLE; // [R07]
						end else begin
							next_acked = 1'b1; // [R06]
						end
					end else if (scl_fall && acked) begin
						next_st = ST_TX; // [R02]
						next_tx_sh = rd_q;
						next_sda_oe = ~rd_q[SESR_MSB];
					end
				end
				default: begin
					next_st = ST_IDLE;
					next_sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= '{scl: 1'b1, sda: 1'b1};
			pin_s2 <= '{scl: 1'b1, sda: 1'b1};
			pin_q <= '{scl: 1'b1, sda: 1'b1};
			slot_s1 <= 3'h0;
			slot_s2 <= 3'h0;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			ack_s3 <= 1'b0;
			st <= ST_IDLE;
			bit_cnt <= SESR_BIT_ZERO;
			sh <= 8'h00;
			addr_hi <= 8'h00;
			addr_cnt <= '0;
			rw <= 1'b0;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			req_tog <= 1'b0;
			tx_sh <= 8'h00;
			acked <= 1'b0;
			rd_q <= 8'h00;
		end else begin
			pin_s1 <= '{scl: scl_in, sda: sda_in};
			pin_s2 <= pin_s1;
			pin_q <= pin_s2;
			slot_s1 <= bus_slot_select_pins;
			slot_s2 <= slot_s1;
			ack_s1 <= ack_tog;
			ack_s2 <= ack_s1;
			ack_s3 <= ack_s2;
			st <= next_st;
			bit_cnt <= next_bit_cnt;
			sh <= next_sh;
			addr_hi <= next_addr_hi;
			addr_cnt <= next_addr_cnt;
			rw <= next_rw;
			sda_oe <= next_sda_oe;
			// Open drain: the pin is only ever pulled low
			sda_out <= 1'b0;
			req_tog <= next_req_tog;
			tx_sh <= next_tx_sh;
			acked <= next_acked;
			rd_q <= next_rd_q;
		end
	end

	// Core side: answers each fetch toggle; address is stable while a fetch is open
	always_comb begin
		next_ack_tog = ack_tog;
		next_rd_data = rd_data;
		if (req_s2 ^ req_s3) begin
			next_rd_data = mem[addr_cnt];
			next_ack_tog = ~ack_tog;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
			ack_tog <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			req_s1 <= req_tog;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
			ack_tog <= next_ack_tog;
			rd_data <= next_rd_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (load_en) begin
			mem[load_addr] <= load_data;
		end
	end

	sequence s_mack_ok;
		st == ST_MACK && acked && scl_fall && !start_det && !stop_det;
	endsequence
	sequence s_nack;
		st == ST_MACK && scl_rise && pin_s2.sda && !start_det && !stop_det;
	endsequence

	chk_ack_resume: assert property (@(posedge link_clk) disable iff (!rst_n) // [R02]
		s_mack_ok |=> st == ST_TX && sda_oe == ~rd_q[SESR_MSB]) else $error("acked byte not followed");
	chk_nack_standby: assert property (@(posedge link_clk) disable iff (!rst_n) // [R07]
		s_nack |=> st == ST_IDLE && !sda_oe) else $error("no-ack did not end read");
	chk_ack_release: assert property (@(posedge link_clk) disable iff (!rst_n) // [R06]
		st == ST_MACK |-> !sda_oe) else $error("data line held in ack slot");
	chk_addr_inc: assert property (@(posedge link_clk) disable iff (!rst_n) // [R04]
		$rose(st == ST_MACK) |-> addr_cnt == MEM_AW'($past(addr_cnt) + 1'b1)) else $error("address not incremented");
	chk_addr_wrap: assert property (@(posedge link_clk) disable iff (!rst_n) // [R05]
		($rose(st == ST_MACK) && $past(addr_cnt) == '1) |-> addr_cnt == '0) else $error("address did not wrap");
	chk_edge_low: assert property (@(posedge link_clk) disable iff (!rst_n) // [R13]
		$changed(sda_oe) |-> !pin_q.scl) else $error("data changed with clock high");
	chk_stop_idle: assert property (@(posedge link_clk) disable iff (!rst_n) // [R14]
		stop_det && !start_det |=> st == ST_IDLE && !sda_oe) else $error("stop not honoured");
	chk_start_sel: assert property (@(posedge link_clk) disable iff (!rst_n) // [R14]
		start_det |=> st == ST_SEL && bit_cnt == SESR_BIT_ZERO) else $error("start not honoured");
	chk_slot_miss: assert property (@(posedge link_clk) disable iff (!rst_n) // [R09]
		(st == ST_SEL && scl_fall && bit_cnt == SESR_BYTE_BITS && !start_det && !stop_det &&
		sh[SESR_SLOT_MSB:SESR_SLOT_LSB] != slot_s2) |=> st == ST_IDLE && !sda_oe) else $error("mismatch answered");
	chk_sel_ack: assert property (@(posedge link_clk) disable iff (!rst_n) // [R10]
		$rose(st == ST_SEL_ACK) |-> sda_oe && rw == $past(sh[SESR_RW_POS])) else $error("select not acked");
	chk_addr_load: assert property (@(posedge link_clk) disable iff (!rst_n) // [R11]
		$rose(st == ST_ALO_ACK) |-> addr_cnt == MEM_AW'({addr_hi, sh})) else $error("address not loaded");
	chk_fetch_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
		(req_s2 ^ req_s3) |=> ack_tog != $past(ack_tog)) else $error("fetch not answered");
endmodule : sesr_eeprom_read
`default_nettype wire

// >>> test/sesr_master.sv
`timescale 1ns/100ps
`default_nettype none
module sesr_master #(
	parameter int H = 30
) (
	// Timing and bus
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_m
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic hw();
		repeat (H) @(negedge clk);
	endtask : hw
	// Short hold after SCL falls so no edge looks like a start or stop
	task automatic start();
		repeat (4) @(negedge clk);
		sda_m = 1'b1;
		hw();
		scl = 1'b1;
		hw();
		sda_m = 1'b0;
		hw();
		scl = 1'b0;
	endtask : start
	task automatic stop();
		repeat (4) @(negedge clk);
		sda_m = 1'b0;
		hw();
		scl = 1'b1;
		hw();
		sda_m = 1'b1;
		hw();
	endtask : stop
	task automatic bitx(input logic b, output logic r);
		repeat (4) @(negedge clk);
		sda_m = b;
		hw();
		scl = 1'b1;
		hw();
		r = sda_line;
		scl = 1'b0;
	endtask : bitx
	// Ninth slot: a=0 acknowledges, a=1 leaves the line released
	task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(a, ack);
	endtask : xbyte
endmodule : sesr_master
`default_nettype wire

// >>> test/serial_eeprom_sequential_read_bench.sv
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_sequential_read_bench;
	// Device type code; value is arbitrary
	localparam logic [3:0] DT = 4'h9;
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b0;
	logic load_en = 1'b0;
	logic [15:0] load_addr = 16'h0000;
	logic [7:0] load_data = 8'h00;
	logic [2:0] slot = 3'h0;
	logic scl, sda_m, sda_out, sda_oe, ak, rr;
	wire logic sda_line = sda_m & ~(sda_oe & ~sda_out);
	logic [7:0] mem [int];
	logic [7:0] q;
	logic [15:0] ptr = 16'h0000;
	logic [15:0] ra;
	int rn;
	int fails = 0;
	int num_checks = 0;

	always #5 core_clk = ~core_clk;
	initial begin
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	sesr_eeprom_read #(.DEV_TYPE(DT)) uut (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .bus_slot_select_pins(slot),
		.load_en(load_en), .load_addr(load_addr), .load_data(load_data));
	sesr_master #(.H(30)) mst (.clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [7:0] expect_at(input logic [15:0] a);
		return mem[int'(a)];
	endfunction : expect_at
	task automatic preload(input logic [15:0] a, input int n);
		for (int k = 0; k < n; k++) begin
			@(negedge core_clk);
			load_en = 1'b1;
			load_addr = a + 16'(k);
			load_data = 8'($urandom);
			mem[int'(load_addr)] = load_data;
		end
		@(negedge core_clk);
		load_en = 1'b0;
	endtask : preload
	task automatic seq_read(input logic rnd, input logic [15:0] a, input int n);
		if (rnd) begin
			mst.start();
			mst.xbyte({DT, slot, 1'b0}, 1'b1, q, ak);
			chk({7'h00, ak}, 8'h00);
			mst.xbyte(a[15:8], 1'b1, q, ak);
			chk({7'h00, ak}, 8'h00);
			mst.xbyte(a[7:0], 1'b1, q, ak);
			chk({7'h00, ak}, 8'h00);
			ptr = a;
		end
		mst.start();
		mst.xbyte({DT, slot, 1'b1}, 1'b1, q, ak);
		chk({7'h00, ak}, 8'h00);
		for (int k = 0; k < n; k++) begin
			mst.xbyte(8'hff, k == n - 1, q, ak);
			chk(q, expect_at(ptr));
			chk({7'h00, ak}, {7'h00, k == n - 1});
			ptr = ptr + 16'h0001;
		end
		// The device must stay off the line after the missing ack
		mst.xbyte(8'hff, 1'b1, q, ak);
		chk(q, 8'hff);
		mst.stop();
	endtask : seq_read
	task automatic test_done();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	initial begin
		#1000000;
		fails++;
		$display("[FAIL] %0t: timeout", $time);
		test_done();
	end
	initial begin
		void'($urandom(8));
		slot = 3'($urandom);
		repeat (6) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		preload(16'hfffe, 4);
		seq_read(1'b1, 16'hfffe, 4);
		$display("test 1 done: wrap");
		preload(ptr, 2);
		seq_read(1'b0, 16'h0000, 2);
		$display("test 2 done: current address");
		mst.start();
		mst.xbyte({DT, ~slot, 1'b1}, 1'b1, q, ak);
		chk({7'h00, ak}, 8'h01);
		mst.stop();
		mst.start();
		mst.xbyte({~DT, slot, 1'b1}, 1'b1, q, ak);
		chk({7'h00, ak}, 8'h01);
		mst.stop();
		$display("test 3 done: wrong slot and type");
		// A stop between the address bytes must leave the counter untouched
		mst.start();
		mst.xbyte({DT, slot, 1'b0}, 1'b1, q, ak);
		chk({7'h00, ak}, 8'h00);
		mst.xbyte(8'h00, 1'b1, q, ak);
		chk({7'h00, ak}, 8'h00);
		mst.stop();
		preload(ptr, 1);
		seq_read(1'b0, 16'h0000, 1);
		$display("test 4 done: aborted address");
		for (int t = 0; t < 6; t++) begin
			ra = 16'($urandom);
			rn = 1 + int'($urandom % 3);
			rr = 1'($urandom);
			preload(rr ? ra : ptr, rn);
			seq_read(rr, ra, rn);
			$display("test %0d done: random", t + 5);
		end
		test_done();
	end
endmodule : serial_eeprom_sequential_read_bench
`default_nettype wire
